// *** core/bridge_cfg_pkg.sv ***
// package: offsets, field positions and reset values of the bridge configuration local view
// assumes: used by bridge_cfg_view, its checker and its testbench
package bridge_cfg_pkg;
  localparam logic [15:0] OFF_IDENTITY = 16'h2000;
  localparam logic [15:0] OFF_CMD_STATUS = 16'h2004;
  localparam logic [15:0] OFF_SUBSYS = 16'h202C;
  localparam logic [15:0] WIN_FIRST = 16'h2000;
  localparam logic [15:0] WIN_LAST = 16'h20FC;
  localparam int BIT_DET_PARITY = 31;
  localparam int BIT_SIG_SYSERR = 30;
  localparam int BIT_RCV_MABORT = 29;
  localparam int BIT_RCV_TABORT = 28;
  localparam int BIT_GEN_TABORT = 27;
  localparam int BIT_DATA_PARITY = 24;
  localparam int BIT_PAR_RESP = 6;
  localparam int BIT_SYSERR_EN = 8;
  localparam int BIT_MASTER_EN = 2;
  localparam int BIT_MEM_EN = 1;
  localparam logic [1:0] DEVSEL_SLOW = 2'h2;
  localparam logic [15:0] STATUS_FIXED = 16'h0030;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] SUBSYS_RESET = 32'h0000_0000;
endpackage

// *** core/bridge_cfg_view.sv ***
// bridge_cfg_view: one storage for the bridge configuration words, seen from the
// local processor and from the pci configuration side.
// assumes: both ports and all event pulses are synchronous to clk_sys.
`timescale 1ns/100ps
module bridge_cfg_view
  import bridge_cfg_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'hABCD // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  // local processor port
  input wire logic locSel,
  input wire logic locWrite,
  input wire logic [15:0] locAddr,
  input wire logic [31:0] locWdata,
  output logic [31:0] locRdata,
  output logic locAck,
  // pci configuration side, already decoded from pci cycles
  input wire logic pciSel,
  input wire logic pciWrite,
  input wire logic [15:0] pciAddr,
  input wire logic [31:0] pciWdata,
  output logic [31:0] pciRdata,
  output logic pciAck,
  // bridge events, one-cycle pulses
  input wire logic parityDetected,
  input wire logic perrSeen,
  input wire logic bridgeMastered,
  input wire logic systemErrorDriven,
  input wire logic masterAbort,
  input wire logic specialCycle,
  input wire logic targetAbortRcvd,
  input wire logic targetAbortGen,
  // control outputs for the rest of the bridge
  output logic parityRespEn,
  output logic perrDriveEn,
  output logic sysErrEn,
  output logic masterEn,
  output logic memEn
);

  typedef struct packed {
    logic [15:0] cmd;
    logic [31:0] subsys;
    logic detParity;
    logic sigSysErr;
    logic rcvMAbort;
    logic rcvTAbort;
    logic genTAbort;
    logic dataParity;
    logic [31:0] locRdata;
    logic locAck;
    logic [31:0] pciRdata;
    logic pciAck;
  } state_t;

  state_t s_q, s_d;
  logic [31:0] idWord;
  logic [31:0] csWord;
  logic [15:0] statusHalf;
  logic locIn;
  logic pciIn;
  // access decode terms
  logic locRead;
  logic locSubWrite;
  logic pciRead;
  logic pciCsWrite;
  logic pciSubWrite;
  // qualified event terms, one per status flag
  logic setDetParity;
  logic setSigSysErr;
  logic setRcvMAbort;
  logic setRcvTAbort;
  logic setGenTAbort;
  logic setDataParity;
  // write-one-clear terms from the pci side
  logic clrDetParity;
  logic clrSigSysErr;
  logic clrRcvMAbort;
  logic clrRcvTAbort;
  logic clrGenTAbort;
  logic clrDataParity;

  // ==========================================================
  // read views of the shared storage
  assign idWord = {DEVICE_CODE, MAKER_CODE};
  // status half: sticky flags, fixed devsel timing and fixed capability bits
  assign statusHalf = {
    s_q.detParity,
    s_q.sigSysErr,
    s_q.rcvMAbort,
    s_q.rcvTAbort,
    s_q.genTAbort,
    DEVSEL_SLOW,
    s_q.dataParity,
    STATUS_FIXED[7:0]
  };
  assign csWord = {statusHalf, s_q.cmd};
  assign locIn = (locAddr >= WIN_FIRST) && (locAddr <= WIN_LAST);

  // pci side sees the same offsets; it never routes through the local port
  assign pciIn = (pciAddr >= WIN_FIRST) && (pciAddr <= WIN_LAST);

  // ==========================================================
  // access decode
  // local accesses end here, so no pci config cycle can start from this port
  assign locRead = locSel && !locWrite && locIn;
  assign locSubWrite = locSel && locWrite && (locAddr == OFF_SUBSYS);
  assign pciRead = pciSel && !pciWrite && pciIn;
  assign pciCsWrite = pciSel && pciWrite && (pciAddr == OFF_CMD_STATUS);
  assign pciSubWrite = pciSel && pciWrite && (pciAddr == OFF_SUBSYS);

  // ==========================================================
  // event qualification
  // detected parity is recorded whatever the response control says; perr only with the response control on
  assign setDetParity = parityDetected;
  assign setSigSysErr = systemErrorDriven;
  assign setRcvMAbort = masterAbort && bridgeMastered && !specialCycle;
  assign setRcvTAbort = targetAbortRcvd && bridgeMastered;
  assign setGenTAbort = targetAbortGen;
  assign setDataParity = perrSeen && bridgeMastered && s_q.cmd[BIT_PAR_RESP];

  // ==========================================================
  // flag clears
  // only a pci write with a one in the flag position clears it; reads never do
  assign clrDetParity = pciCsWrite && pciWdata[BIT_DET_PARITY];
  assign clrSigSysErr = pciCsWrite && pciWdata[BIT_SIG_SYSERR];
  assign clrRcvMAbort = pciCsWrite && pciWdata[BIT_RCV_MABORT];
  assign clrRcvTAbort = pciCsWrite && pciWdata[BIT_RCV_TABORT];
  assign clrGenTAbort = pciCsWrite && pciWdata[BIT_GEN_TABORT];
  assign clrDataParity = pciCsWrite && pciWdata[BIT_DATA_PARITY];

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.locAck = locSel;
    s_d.pciAck = pciSel;
    // reads only select words, so no flag is cleared by a read
    s_d.locRdata = ZERO_WORD;
    s_d.pciRdata = ZERO_WORD;
    if (locRead) begin
      case (locAddr)
        OFF_IDENTITY: s_d.locRdata = idWord;
        OFF_CMD_STATUS: s_d.locRdata = csWord;
        OFF_SUBSYS: s_d.locRdata = s_q.subsys;
        default: s_d.locRdata = ZERO_WORD;
      endcase
    end
    if (pciRead) begin
      case (pciAddr)
        OFF_IDENTITY: s_d.pciRdata = idWord;
        OFF_CMD_STATUS: s_d.pciRdata = csWord;
        OFF_SUBSYS: s_d.pciRdata = s_q.subsys;
        default: s_d.pciRdata = ZERO_WORD;
      endcase
    end
    // pci host owns the command bits
    if (pciCsWrite) s_d.cmd = pciWdata[15:0];
    // a flag only drops on an explicit clear
    if (clrDetParity) s_d.detParity = 1'b0;
    if (clrSigSysErr) s_d.sigSysErr = 1'b0;
    if (clrRcvMAbort) s_d.rcvMAbort = 1'b0;
    if (clrRcvTAbort) s_d.rcvTAbort = 1'b0;
    if (clrGenTAbort) s_d.genTAbort = 1'b0;
    if (clrDataParity) s_d.dataParity = 1'b0;
    // local writes touch only the subsystem word; the local write wins a same-cycle collision
    if (pciSubWrite) s_d.subsys = pciWdata;
    if (locSubWrite) s_d.subsys = locWdata;
    // event sets come last so a set beats a clear in the same cycle
    if (setDetParity) s_d.detParity = 1'b1;
    if (setSigSysErr) s_d.sigSysErr = 1'b1;
    if (setRcvMAbort) s_d.rcvMAbort = 1'b1;
    if (setRcvTAbort) s_d.rcvTAbort = 1'b1;
    if (setGenTAbort) s_d.genTAbort = 1'b1;
    if (setDataParity) s_d.dataParity = 1'b1;
  end

  // ==========================================================
  // state register
  // async reset loads constants only, so every flag and control restarts at zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.subsys <= SUBSYS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign locRdata = s_q.locRdata;
  assign locAck = s_q.locAck;
  assign pciRdata = s_q.pciRdata;
  assign pciAck = s_q.pciAck;
  assign parityRespEn = s_q.cmd[BIT_PAR_RESP];
  // with the response control off detected parity errors are only recorded, never reported; perr is not recorded
  assign perrDriveEn = s_q.cmd[BIT_PAR_RESP];
  assign sysErrEn = s_q.cmd[BIT_SYSERR_EN];
  assign masterEn = s_q.cmd[BIT_MASTER_EN];
  assign memEn = s_q.cmd[BIT_MEM_EN];

endmodule // bridge_cfg_view

// *** tb/bridge_cfg_view_checker.sv ***
// checker: port assertions for bridge_cfg_view
// assumes: bound to every instance, one clock clk_sys
`timescale 1ns/100ps
module bridge_cfg_view_checker
  import bridge_cfg_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'hABCD // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic locSel,
  input wire logic locWrite,
  input wire logic [15:0] locAddr,
  input wire logic [31:0] locRdata,
  input wire logic locAck,
  input wire logic pciSel,
  input wire logic pciWrite,
  input wire logic [15:0] pciAddr,
  input wire logic [31:0] pciWdata,
  input wire logic pciAck,
  input wire logic parityDetected,
  input wire logic parityRespEn,
  input wire logic perrDriveEn,
  input wire logic sysErrEn,
  input wire logic masterEn,
  input wire logic memEn
);
  // =====
  // checks pause under reset; flags are only visible through status reads
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rdSt = locSel && !locWrite && locAddr == OFF_CMD_STATUS;
  wire rdId = locSel && !locWrite && locAddr == OFF_IDENTITY;
  wire rdOut = locSel && !locWrite && locAddr > WIN_LAST;
  wire wrCs = pciSel && pciWrite && pciAddr == OFF_CMD_STATUS;
  wire [3:0] ctl = {parityRespEn, sysErrEn, masterEn, memEn};
  a_loc_ack: assert property (locSel |=> locAck) else $error("local ack late");
  a_pci_ack: assert property (pciSel |=> pciAck) else $error("pci ack late");
  a_out_zero: assert property (rdOut |=> locRdata == ZERO_WORD) else $error("read outside window not zero");
  a_id_word: assert property (rdId |=> locRdata == {DEVICE_CODE, MAKER_CODE}) else $error("identity");
  a_devsel_slow: assert property (rdSt |=> locRdata[26:25] == DEVSEL_SLOW) else $error("devsel");
  a_parity_kept: assert property (parityDetected ##2 rdSt |=> locRdata[BIT_DET_PARITY]) else $error("parity");
  a_perr_off: assert property (wrCs && !pciWdata[BIT_PAR_RESP] |=> !perrDriveEn) else $error("perr driven");
  a_cmd_hold: assert property (!pciSel [*3] |-> $stable(ctl)) else $error("controls moved without pci write");
  c_rd: cover property (rdSt);
  c_pci: cover property (pciSel);
  c_par: cover property (parityDetected && !parityRespEn);
endmodule // bridge_cfg_view_checker
bind bridge_cfg_view bridge_cfg_view_checker #(.DEVICE_CODE(DEVICE_CODE), .MAKER_CODE(MAKER_CODE)) chk (.*);

// *** tb/cfg_requester.sv ***
// model: processor-like requester for one access port of the view
// assumes: request taken at a rising edge, ack exactly one cycle later
`timescale 1ns/100ps
module cfg_requester (
  input wire logic clk_sys,
  input wire logic ack,
  input wire logic [31:0] rdata,
  output logic sel,
  output logic wr,
  output logic [15:0] addr,
  output logic [31:0] wdata
);
  // =====
  // released lines show the inverse, so a stale copy is never mistaken for a request
  initial begin
    {sel, wr, addr, wdata} = '0;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    @(negedge clk_sys);
    {sel, wr, addr, wdata} = {1'b1, w, a, d};
    @(negedge clk_sys);
    {sel, wr, addr, wdata} = {1'b0, ~w, ~a, ~d};
    q = ack ? rdata : 'x; // ack stands one cycle only
  endtask
endmodule // cfg_requester

// *** tb/test_bridge_cfg_view.sv ***
// testbench: bridge_cfg_view with two requester models and pulsed events
// assumes: package first, checker bound from its own file
`timescale 1ns/100ps
module test_bridge_cfg_view;
  import bridge_cfg_pkg::*;
  localparam logic [31:0] ST0 = 32'h0430_0000; // slow devsel plus fixed capability bits
  logic clk_sys, rst, locSel, locWrite, locAck, pciSel, pciWrite, pciAck, parityDetected, perrSeen;
  logic bridgeMastered, systemErrorDriven, masterAbort, specialCycle, targetAbortRcvd, targetAbortGen;
  logic parityRespEn, perrDriveEn, sysErrEn, masterEn, memEn;
  logic [15:0] locAddr, pciAddr;
  logic [31:0] locWdata, locRdata, pciWdata, pciRdata, q;
  logic [7:0] ev;
  // rows: event pulse, expected flags 31:24 (special cycle, unmastered and perr without response set none)
  logic [15:0] rows [9] = '{16'h8080, 16'h4040, 16'h2120, 16'h3100, 16'h0910, 16'h0408, 16'h0300, 16'h2000,
    16'h0800};
  int errCount = 0, compares = 0, cycles = 0;
  assign {parityDetected, systemErrorDriven, masterAbort, specialCycle, targetAbortRcvd, targetAbortGen,
    perrSeen, bridgeMastered} = ev;
  bridge_cfg_view uut (.*);
  cfg_requester cpu (.clk_sys, .ack(locAck), .rdata(locRdata), .sel(locSel), .wr(locWrite), .addr(locAddr),
    .wdata(locWdata));
  cfg_requester host (.clk_sys, .ack(pciAck), .rdata(pciRdata), .sel(pciSel), .wr(pciWrite), .addr(pciAddr),
    .wdata(pciWdata));
  // =====
  // clock, and a ceiling far above the roughly 100 cycles the run needs
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errCount++;
      completeRun();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(input logic [7:0] e);
    @(negedge clk_sys) ev = e;
    @(negedge clk_sys) ev = 8'h00;
  endtask
  task automatic completeRun();
    if (errCount == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // =====
  // main sequence: reset, window accesses, event rows, parity report, set/clear collision, second reset
  initial begin
    ev = 8'h00;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk("controls reset", {27'h0, parityRespEn, perrDriveEn, sysErrEn, masterEn, memEn}, 32'h0);
    cpu.xfer(1'b1, OFF_SUBSYS, 32'h5A5A_C3C3, q);
    host.xfer(1'b0, OFF_SUBSYS, 32'h0, q);
    chk("subsystem", q, 32'h5A5A_C3C3);
    cpu.xfer(1'b1, OFF_IDENTITY, 32'hFFFF_FFFF, q);
    cpu.xfer(1'b1, OFF_CMD_STATUS, 32'hFFFF_FFFF, q);
    cpu.xfer(1'b0, OFF_IDENTITY, 32'h0, q);
    chk("identity", q, 32'h1234_ABCD);
    cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
    chk("status", q, ST0);
    cpu.xfer(1'b0, 16'h2100, 32'h0, q);
    chk("outside", q, 32'h0);
    foreach (rows[i]) begin
      pulse(rows[i][15:8]);
      repeat (2) begin
        cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
        chk("flags", q, ST0 | {rows[i][7:0], 24'h0});
      end
      host.xfer(1'b1, OFF_CMD_STATUS, 32'hFFFF_0000, q);
    end
    host.xfer(1'b1, OFF_CMD_STATUS, 32'h0000_0146, q);
    @(negedge clk_sys);
    chk("controls", {27'h0, parityRespEn, perrDriveEn, sysErrEn, masterEn, memEn}, 32'h1F);
    pulse(8'h03);
    cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
    chk("report", q, ST0 | 32'h0100_0146);
    // awkward case: a parity event and its write-one clear land on the same edge
    fork
      pulse(8'h80);
      host.xfer(1'b1, OFF_CMD_STATUS, 32'h8100_0146, q);
    join
    cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
    chk("set beats clear", q, ST0 | 32'h8000_0146);
    // perr with response on but not bridge-mastered must not report
    pulse(8'h02);
    cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
    chk("perr not mastered", q, ST0 | 32'h8000_0146);
    // mid-run reset: flags, controls and subsystem word all return to zero
    @(negedge clk_sys) rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk("controls reset2", {27'h0, parityRespEn, perrDriveEn, sysErrEn, masterEn, memEn}, 32'h0);
    cpu.xfer(1'b0, OFF_CMD_STATUS, 32'h0, q);
    chk("status reset2", q, ST0);
    host.xfer(1'b0, OFF_SUBSYS, 32'h0, q);
    chk("subsystem reset2", q, SUBSYS_RESET);
    completeRun();
  end
endmodule // test_bridge_cfg_view
